// file: core/dac_serial_input_port.sv
// Serial input port of a multiplying DAC: framed 16-bit words, daisy chain
// output and readback of the DAC register.
// Assumes the serial clock runs well below sys_clk_i / 4, since every pin
// is sampled through two flip-flops before its edges are found.
// Readback data leaves in the frame after the readback word, so the host
// spends one extra frame for each read.
// Commands other than load, readback and edge are latched and ignored.
`timescale 1ns/10ps
`include "dac_port_cfg.svh"

module dac_serial_input_port
    import dac_port_pkg::*;
#(
    parameter int        DAC_BITS     = `DAC_BITS,
    parameter int        DATA_LSB     = `DATA_LSB,
    parameter int        CMD_MSB      = `CMD_MSB,
    parameter int        CMD_LSB      = `CMD_LSB,
    parameter int        EDGE_SEL_BIT = `EDGE_SEL_BIT,
    parameter logic [3:0] CMD_LOAD     = `CMD_LOAD,
    parameter logic [3:0] CMD_READBACK = `CMD_READBACK,
    parameter logic [3:0] CMD_EDGE     = `CMD_EDGE
) (
    input  wire logic                sys_clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                shift_clock_in_i,
    input  wire logic                serial_data_in_i,
    input  wire logic                frame_select_n_i,
    output logic                     chain_data_out_o,
    output logic [DAC_BITS-1:0]      dac_value_o,
    output logic                     edge_rising_o,
    output logic                     frame_active_o,
    output logic                     word_latched_o,
    output logic                     readback_armed_o
);

    localparam int CMD_W = CMD_MSB - CMD_LSB + 1;
    // Count value at which the sixteenth active edge arrives
    localparam logic [`COUNT_BITS-1:0] LAST_COUNT =
        `COUNT_BITS'(`WORD_BITS - 1);

    // ======================================================================
    // State record
    typedef struct packed {
        port_state_e                state;
        logic                       sck_prev;
        logic [`COUNT_BITS-1:0]     count;
        word_t                      shift;
        logic [DAC_BITS-1:0]        dac;
        logic                       edge_rise;
        logic                       out_bit;
        logic                       latched;
        logic                       readback;
        // Own flop, so frame_active_o carries no decode
        logic                       framed;
    } port_regs_s;

    port_regs_s st;
    port_regs_s next_st;

    // ======================================================================
    // Pin synchronisers
    localparam int         PIN_SCK   = 0;
    localparam int         PIN_DIN   = 1;
    localparam int         PIN_FRAME = 2;
    // Reset levels: frame select idles high, the others low
    localparam logic [2:0] PIN_IDLE  = 3'b100;

    logic [2:0] pins_s;
    logic       sck_s;
    logic       din_s;
    logic       frame_n_s;

    // A frame line that starts high avoids a false frame after reset
    pin_sync #(
        .WIDTH       (3),
        .RESET_VAL   (PIN_IDLE)
    ) u_pin_sync (
        .sys_clk_i   (sys_clk_i),
        .reset_n_i   (reset_n_i),
        .pin_i       ({frame_select_n_i, serial_data_in_i,
                       shift_clock_in_i}),
        .pin_o       (pins_s)
    );

    assign frame_n_s = pins_s[PIN_FRAME];
    assign din_s     = pins_s[PIN_DIN];
    assign sck_s     = pins_s[PIN_SCK];

    // ======================================================================
    // Word decode helpers
    function automatic logic [CMD_W-1:0] cmd_of(input word_t w);
        cmd_of = w[CMD_MSB:CMD_LSB];
    endfunction

    // Command decodes of a completed word
    function automatic logic is_load(input word_t w);
        is_load = (cmd_of(w) == CMD_LOAD);
    endfunction

    function automatic logic is_readback(input word_t w);
        is_readback = (cmd_of(w) == CMD_READBACK);
    endfunction

    function automatic logic is_edge_cmd(input word_t w);
        is_edge_cmd = (cmd_of(w) == CMD_EDGE);
    endfunction

    function automatic word_t readback_word(input logic [DAC_BITS-1:0] d);
        word_t w;
        w = `SHIFT_RESET;
        w[DATA_LSB +: DAC_BITS] = d;
        readback_word = w;
    endfunction

    // ======================================================================
    // Next-state logic
    logic  sck_rise;
    logic  sck_fall;
    logic  active_edge;
    logic  out_edge;
    logic  last_edge;
    word_t shifted;

    always_comb begin
        next_st     = st;
        sck_rise    = sck_s & ~st.sck_prev;
        sck_fall    = ~sck_s & st.sck_prev;
        active_edge = st.edge_rise ? sck_rise : sck_fall;
        out_edge    = st.edge_rise ? sck_fall : sck_rise;
        shifted     = {st.shift[`WORD_BITS-2:0], din_s};
        last_edge   = (st.count == LAST_COUNT);

        next_st.sck_prev = sck_s;
        next_st.latched  = 1'b0;

        unique case (st.state)
            PORT_IDLE: begin
                if (!frame_n_s) begin
                    next_st.state = PORT_SHIFT;
                    next_st.count = '0;
                end
            end
            PORT_SHIFT, PORT_HELD: begin
                if (frame_n_s) begin
                    next_st.state = PORT_IDLE;
                end else if (active_edge) begin
                    next_st.shift = shifted;
                    if (st.state == PORT_SHIFT) begin
                        next_st.count =
                            st.count + `COUNT_BITS'(1);
                        if (last_edge) begin
                            next_st.state    = PORT_HELD;
                            next_st.latched  = 1'b1;
                            next_st.readback = 1'b0;
                            if (is_load(shifted)) begin
                                next_st.dac =
                                    shifted[DATA_LSB +: DAC_BITS];
                            end else if (is_edge_cmd(shifted)) begin
                                next_st.edge_rise = shifted[EDGE_SEL_BIT];
                            end else if (is_readback(shifted)) begin
                                next_st.shift    = readback_word(st.dac);
                                next_st.readback = 1'b1;
                            end
                        end
                    end
                end else if (out_edge) begin
                    next_st.out_bit = st.shift[`WORD_BITS-1];
                end
            end
            default: begin
                next_st.state = PORT_IDLE;
            end
        endcase

        next_st.framed = (next_st.state != PORT_IDLE);
    end

    // ======================================================================
    // State register
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st.state     <= PORT_IDLE;
            st.sck_prev  <= 1'b0;
            st.count     <= '0;
            st.shift     <= `SHIFT_RESET;
            st.dac       <= '0;
            st.edge_rise <= `EDGE_RISE_RESET;
            st.out_bit   <= 1'b0;
            st.latched   <= 1'b0;
            st.readback  <= 1'b0;
            st.framed    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // Outputs, all straight from the state record
    assign chain_data_out_o = st.out_bit;
    assign dac_value_o      = st.dac;
    assign edge_rising_o    = st.edge_rise;
    // No output is decoded, so none can glitch
    assign frame_active_o   = st.framed;
    assign word_latched_o   = st.latched;
    assign readback_armed_o = st.readback;

endmodule

// file: core/dac_port_cfg.svh
// Constants of the DAC serial input port: word layout, commands, reset values.
// Assumes the includer is a module or package compiled after this header.
// Contract
// - Default capture on falling serial clock edge.
// - Control word can select rising capture edge.
// - Sixteen-bit register shifts once per active edge.
// - After power-up, falling edge capture is selected.
// - Frame fall enables inputs; high keeps idle.
// - Count active edges; latch on sixteenth.
// - chain_data_out changes on the opposite edge.
// - Shifted-out bits appear on chain_data_out.
// - Readback command presents DAC register on output.
`ifndef DAC_PORT_CFG_SVH
`define DAC_PORT_CFG_SVH

// ==========================================================================
// Word layout
`define WORD_BITS       16
`define COUNT_BITS      5
`define DAC_BITS        12
`define DATA_LSB        0
`define CMD_MSB         15
`define CMD_LSB         12
`define EDGE_SEL_BIT    0

// ==========================================================================
// Command codes in the top field
`define CMD_LOAD        4'h0
`define CMD_READBACK    4'h2
`define CMD_EDGE        4'h9

// ==========================================================================
// Reset values and synchroniser depth
`define SHIFT_RESET     16'h0000
`define EDGE_RISE_RESET 1'b0
`define SYNC_STAGES     2

`endif

// file: core/dac_port_pkg.sv
// Types shared by the DAC serial input port files.
// Assumes dac_port_cfg.svh is on the include path.
`include "dac_port_cfg.svh"

package dac_port_pkg;

    // ======================================================================
    // Frame sequencer, Gray coded along idle, shift, held
    typedef enum logic [1:0] {
        PORT_IDLE  = 2'b00,
        PORT_SHIFT = 2'b01,
        PORT_HELD  = 2'b11
    } port_state_e;

    typedef logic [`WORD_BITS-1:0] word_t;

endpackage

// file: core/pin_sync.sv
// Two-stage synchroniser for a group of pins from outside the clock domain.
// Assumes the pins are quasi-static relative to sys_clk_i.
`timescale 1ns/10ps

module pin_sync #(
    parameter int               WIDTH     = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] pin_o
);

    // ======================================================================
    // Per-pin flop pair; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
            logic meta;
            logic held;
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                // Idle level as reset value, so no false edge after reset
                if (!reset_n_i) begin
                    meta <= RESET_VAL[g];
                    held <= RESET_VAL[g];
                end else begin
                    meta <= pin_i[g];
                    held <= meta;
                end
            end
            assign pin_o[g] = held;
        end
    endgenerate

endmodule

// file: tb/dac_port_checker.sv
// Assertions on the pins of the DAC serial input port.
// Assumes it is bound into dac_serial_input_port, one clock domain.
`timescale 1ns/10ps
module dac_port_checker #(
    parameter int DAC_BITS = 12
) (
    input wire logic                sys_clk_i,
    input wire logic                reset_n_i,
    input wire logic                shift_clock_in_i,
    input wire logic                serial_data_in_i,
    input wire logic                frame_select_n_i,
    input wire logic                chain_data_out_o,
    input wire logic [DAC_BITS-1:0] dac_value_o,
    input wire logic                edge_rising_o,
    input wire logic                frame_active_o,
    input wire logic                word_latched_o,
    input wire logic                readback_armed_o
);
    // ====
    // Pins take two or three cycles through the synchroniser
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    AST_START: assert property ($rose(reset_n_i) |-> dac_value_o == '0
        && !edge_rising_o) else $error("not cleared at reset");
    AST_FRAME_ON: assert property ($fell(frame_select_n_i) |->
        ##[1:5] frame_active_o) else $error("frame not taken");
    AST_IDLE: assert property (!frame_active_o |-> !word_latched_o)
        else $error("latch while idle");
    AST_PULSE: assert property (word_latched_o |=> !word_latched_o)
        else $error("latch pulse too long");
    AST_EDGE_SEL: assert property (word_latched_o |->
        $past(shift_clock_in_i, 2) == $past(edge_rising_o)) else $error("edge");
    AST_DAC: assert property ($changed(dac_value_o) |-> word_latched_o)
        else $error("dac moved without latch");
    AST_EDGE_HOLD: assert property ($changed(edge_rising_o) |->
        word_latched_o) else $error("edge moved without latch");
    AST_OUT: assert property ($changed(chain_data_out_o) |->
        frame_active_o || $past(frame_active_o)) else $error("out unframed");
    AST_ARMED: assert property ($changed(readback_armed_o) |->
        word_latched_o) else $error("readback flag moved without latch");
endmodule

bind dac_serial_input_port dac_port_checker #(.DAC_BITS(DAC_BITS)) chk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .shift_clock_in_i(shift_clock_in_i), .serial_data_in_i(serial_data_in_i),
    .frame_select_n_i(frame_select_n_i), .chain_data_out_o(chain_data_out_o),
    .dac_value_o(dac_value_o), .edge_rising_o(edge_rising_o),
    .frame_active_o(frame_active_o), .word_latched_o(word_latched_o),
    .readback_armed_o(readback_armed_o));

// file: tb/serial_host_model.sv
// Host model: frames words, clocks them MSB first, gathers chain bits.
// Assumes sys_clk_i paces it; a serial half period is four of its cycles.
`timescale 1ns/10ps
module serial_host_model (
    input  wire logic sys_clk_i,
    input  wire logic chain_i,
    output logic      sclk_o,
    output logic      sdi_o,
    output logic      frame_n_o
);
    logic        rise = 1'b0;
    logic [31:0] rx;
    initial {sclk_o, sdi_o, frame_n_o} = 3'b001;
    task automatic half();
        repeat (4) @(posedge sys_clk_i);
    endtask
    // ====
    // framed word
    task automatic send(input logic [31:0] w, input int n);
        sclk_o <= rise;
        half();
        frame_n_o <= 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            if (i < n - 1) rx = {rx[30:0], chain_i};
            sdi_o <= w[i];
            sclk_o <= !rise;
            half();
            sclk_o <= rise;
            half();
        end
        rx = {rx[30:0], chain_i};
        frame_n_o <= 1'b1;
        // Released data line must not keep its last bit
        sdi_o <= !sdi_o;
        half();
        half();
    endtask
endmodule

// file: tb/tb_top.sv
// Random and corner words through the DAC serial input port.
// Assumes the checker is bound in and the config header is on the path.
`timescale 1ns/10ps
`include "dac_port_cfg.svh"
module tb_top;
    import dac_port_pkg::*;
    logic        sys_clk_i, reset_n_i, sclk, sdi, frame_n, chain;
    logic        edge_rise, armed;
    logic [11:0] dac, dac_exp;
    word_t       prev, w;
    int          errors, samples_checked;
    serial_host_model host (.sys_clk_i(sys_clk_i), .chain_i(chain),
        .sclk_o(sclk), .sdi_o(sdi), .frame_n_o(frame_n));
    dac_serial_input_port uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .shift_clock_in_i(sclk), .serial_data_in_i(sdi),
        .frame_select_n_i(frame_n), .chain_data_out_o(chain),
        .dac_value_o(dac), .edge_rising_o(edge_rise), .frame_active_o(),
        .word_latched_o(), .readback_armed_o(armed));
    function automatic logic [11:0] next_dac(word_t c, logic [11:0] d);
        return (c[15:12] == `CMD_LOAD) ? c[11:0] : d;
    endfunction
    task automatic check(input string what, input word_t e, input word_t g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic word(input word_t c);
        host.send({16'h0000, c}, 16);
        check("chain", prev, host.rx[15:0]);
        dac_exp = next_dac(c, dac_exp);
        check("dac", {4'h0, dac_exp}, {4'h0, dac});
        prev = (c[15:12] == `CMD_READBACK) ? {4'h0, dac_exp} : c;
    endtask
    task automatic rst();
        reset_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        {prev, dac_exp} = '0;
        check("dac", 16'h0000, {4'h0, dac});
        check("edge", 16'h0000, {15'h0, edge_rise});
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // Whole run is near 3000 cycles
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        errors++;
        end_sim();
    end
    initial begin
        {errors, samples_checked} = '0;
        reset_n_i = 1'b0;
        void'($urandom(99));
        rst();
        word({`CMD_LOAD, 12'hfff});
        word({`CMD_LOAD, 12'h000});
        repeat (5) word({`CMD_LOAD, 12'($urandom)});
        $display("test load done");
        word({`CMD_EDGE, 12'h001});
        check("edge", 16'h0001, {15'h0, edge_rise});
        host.rise = 1'b1;
        repeat (4) word({`CMD_LOAD, 12'($urandom)});
        word({`CMD_EDGE, 12'h000});
        check("edge", 16'h0000, {15'h0, edge_rise});
        host.rise = 1'b0;
        $display("test edge done");
        word({`CMD_READBACK, 12'($urandom)});
        check("armed", 16'h0001, {15'h0, armed});
        word({4'h1, 12'($urandom)});
        check("armed", 16'h0000, {15'h0, armed});
        $display("test readback done");
        w = {`CMD_LOAD, 12'($urandom)};
        host.send({w, 16'h5a3c}, 32);
        check("chain", prev, host.rx[31:16]);
        check("chain", w, host.rx[15:0]);
        dac_exp = next_dac(w, dac_exp);
        check("dac", {4'h0, dac_exp}, {4'h0, dac});
        prev = 16'h5a3c;
        $display("test chain done");
        host.send(32'h0000_0123, 10);
        check("dac", {4'h0, dac_exp}, {4'h0, dac});
        prev = {prev[5:0], 10'h123};
        word({`CMD_LOAD, 12'h5a5});
        $display("test abort done");
        word({`CMD_EDGE, 12'h001});
        check("edge", 16'h0001, {15'h0, edge_rise});
        rst();
        word({`CMD_LOAD, 12'h800});
        $display("test reset done");
        end_sim();
    end
endmodule
